// >>> design/ssc_top.sv
// ssc_top: step/dir front end, microstep table, serial command port and stand-alone setup
// assumes an analog side that returns comparator flags and a load level on ref_clk
`timescale 1ns/100ps
`default_nettype none
module ssc_top
    import ssc_pkg::*;
(
    // system clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial port, its clock is the link domain
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    // motion controller
    input wire logic step_in,
    input wire logic dir_in,
    // stand-alone select
    input wire logic standalone_select_pin,
    // analog side
    input wire logic coil_a_over,
    input wire logic coil_b_over,
    input wire logic [3:0] load_level,
    // coil targets and chopper phases
    output logic signed [8:0] coil_a_target,
    output logic signed [8:0] coil_b_target,
    output ssc_chst_t chop_a_phase,
    output ssc_chst_t chop_b_phase,
    output logic interp_enable
);
    // link domain state
    logic link_rst_n;
    logic [4:0] bit_cnt;
    logic [19:0] rx_shift;
    logic [19:0] rx_hold;
    logic rx_toggle;
    // ref domain state
    ssc_pins_t pins_meta;
    ssc_pins_t pins;
    logic step_prev;
    logic cs_prev;
    logic toggle_seen;
    logic [19:0] status_frz;
    ssc_cfg_t cfg;
    ssc_cfg_t sa_cfg;
    logic [9:0] usteps;
    logic dir_last;
    logic signed [8:0] coil_direct_a;
    logic signed [8:0] coil_direct_b;
    logic step_rise;
    logic step_fall;
    logic step_event;
    logic cs_rise;
    logic apply;
    logic [9:0] step_size;
    logic [4:0] eff_scale;
    logic signed [6:0] scale_mul;
    logic signed [8:0] sine_a;
    logic signed [8:0] sine_b;
    logic signed [8:0] sel_a;
    logic signed [8:0] sel_b;
    logic signed [15:0] prod_a;
    logic signed [15:0] prod_b;
    logic standalone_resolution_pin;
    logic standalone_hysteresis_pin;
    logic standalone_current_pin;
    logic standalone_s;

    // ---------------- link domain ----------------
    // chip select high holds the frame logic in reset
    assign link_rst_n = rst_n & ~chip_sel_n;

    // count and shift the command bits, saturating past a word
    always_ff @(posedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt <= 5'h00;
            rx_shift <= 20'h00000;
        end else begin
            rx_shift <= {rx_shift[18:0], serial_data_in};
            if (bit_cnt != CNT_SAT) bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // word held at the 20th bit, an extra bit flips the toggle back
    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hold <= 20'h00000;
            rx_toggle <= 1'b0;
        end else if (bit_cnt == LAST_BIT) begin
            rx_hold <= {rx_shift[18:0], serial_data_in};
            rx_toggle <= ~rx_toggle;
        end else if (bit_cnt == OVER_BIT) begin
            rx_toggle <= ~rx_toggle;
        end
    end

    // status out on falling edges; status frozen while select is low
    always_ff @(negedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) serial_data_out <= 1'b0;
        else if (bit_cnt <= LAST_BIT) serial_data_out <= status_frz[LAST_BIT - bit_cnt];
        else serial_data_out <= 1'b0;
    end

    // ---------------- ref domain ----------------
    // two-stage synchroniser for pins and the word toggle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta <= '{cs_n: 1'b1, default: 1'b0};
            pins <= '{cs_n: 1'b1, default: 1'b0};
        end else begin
            pins_meta <= '{step: step_in, dir: dir_in, cs_n: chip_sel_n, sdi: serial_data_in,
                sck: serial_clk, standalone: standalone_select_pin, over_a: coil_a_over,
                over_b: coil_b_over, toggle: rx_toggle};
            pins <= pins_meta;
        end
    end

    // edge history for step and chip select
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            step_prev <= pins.step;
            cs_prev <= pins.cs_n;
        end
    end

    assign standalone_s = pins.standalone;
    assign standalone_resolution_pin = pins.sdi;
    assign standalone_hysteresis_pin = pins.sck;
    assign standalone_current_pin = pins.cs_n;

    assign step_rise = pins.step & ~step_prev;
    assign step_fall = ~pins.step & step_prev;
    assign step_event = step_rise | (cfg.both_edge_step_select & step_fall);
    assign cs_rise = pins.cs_n & ~cs_prev;

    // apply only when a complete word arrived in this frame
    assign apply = cs_rise & (pins.toggle != toggle_seen) & ~standalone_s;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) toggle_seen <= 1'b0;
        else if (cs_rise) toggle_seen <= pins.toggle;
    end

    // stand-alone setup from the three serial pins
    always_comb begin
        sa_cfg = CFG_RESET;
        sa_cfg.microstep_resolution = standalone_resolution_pin ? RES_16 : RES_256;
        sa_cfg.hysteresis_end_value = SA_HYSTERESIS_END_VALUE;
        sa_cfg.hysteresis_start_value = standalone_hysteresis_pin ? SA_HYSTERESIS_START_VALUE_HI : SA_HYSTERESIS_START_VALUE_LO;
        sa_cfg.current_scale = standalone_current_pin ? SA_CS_HI : SA_CS_LO;
    end

    // setup register, serial writes or stand-alone defaults
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (standalone_s) begin
            cfg <= sa_cfg;
        end else if (apply) begin
            case (rx_hold[19:18])
                CMD_STEP: begin
                    cfg.direct_mode <= rx_hold[F_DIRECT];
                    cfg.both_edge_step_select <= rx_hold[F_BOTH_EDGE_STEP_SELECT];
                    cfg.microstep_resolution <= rx_hold[F_RES +: 4];
                end
                CMD_CHOP: begin
                    cfg.chop_mode <= ssc_chop_t'(rx_hold[F_CHOP]);
                    cfg.hysteresis_end_value <= rx_hold[F_HYSTERESIS_END_VALUE +: 4];
                    cfg.hysteresis_start_value <= rx_hold[F_HYSTERESIS_START_VALUE +: 3];
                end
                CMD_CURR: begin
                    cfg.current_scale <= rx_hold[F_CSCALE +: 5];
                    cfg.load_adapt <= rx_hold[F_LOAD];
                end
                default: cfg <= cfg;
            endcase
        end
    end

    // direct coil values written over the serial port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_direct_a <= 9'sh000;
            coil_direct_b <= 9'sh000;
        end else if (apply && rx_hold[19:18] == CMD_COIL) begin
            coil_direct_a <= $signed(rx_hold[F_COIL_A +: 9]);
            coil_direct_b <= $signed(rx_hold[F_COIL_B +: 9]);
        end
    end

    // step size from resolution, codes above full step act as full step
    always_comb begin
        if (cfg.microstep_resolution > RES_FULL) step_size = 10'h100;
        else step_size = 10'h001 << cfg.microstep_resolution;
    end

    // microstep counter, direction taken at the active edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            usteps <= 10'h000;
            dir_last <= 1'b0;
        end else if (step_event && !cfg.direct_mode) begin
            usteps <= pins.dir ? usteps - step_size : usteps + step_size;
            dir_last <= pins.dir;
        end
    end

    // sine for coil a, cosine for coil b
    ssc_sine_lut u_sine_a (
        .phase(usteps),
        .sample(sine_a)
    );
    ssc_sine_lut u_sine_b (
        .phase(usteps + COS_OFFSET),
        .sample(sine_b)
    );

    // load level caps the current scale when enabled
    always_comb begin
        if (cfg.load_adapt && cfg.current_scale > {load_level, 1'b1}) eff_scale = {load_level, 1'b1};
        else eff_scale = cfg.current_scale;
        scale_mul = $signed({2'b00, eff_scale} + 7'h01);
        sel_a = cfg.direct_mode ? coil_direct_a : sine_a;
        sel_b = cfg.direct_mode ? coil_direct_b : sine_b;
        prod_a = sel_a * scale_mul;
        prod_b = sel_b * scale_mul;
    end

    // scaled coil targets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_a_target <= 9'sh000;
            coil_b_target <= 9'sh000;
        end else begin
            coil_a_target <= prod_a[13:5];
            coil_b_target <= prod_b[13:5];
        end
    end

    ssc_chopper u_chop_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .spread(cfg.chop_mode == CHOP_SPREAD),
        .hyst_len({2'b00, cfg.hysteresis_start_value} + {1'b0, cfg.hysteresis_end_value}),
        .over(pins.over_a),
        .phase_st(chop_a_phase)
    );
    ssc_chopper u_chop_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .spread(cfg.chop_mode == CHOP_SPREAD),
        .hyst_len({2'b00, cfg.hysteresis_start_value} + {1'b0, cfg.hysteresis_end_value}),
        .over(pins.over_b),
        .phase_st(chop_b_phase)
    );

    // status word, frozen while a frame runs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_frz <= 20'h00000;
        end else if (pins.cs_n) begin
            status_frz <= {1'b0, usteps, standalone_s, cfg.direct_mode, load_level, dir_last,
                pins.over_a, pins.over_b};
        end
    end

    // output enable only in a serial frame, never stand-alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_oe <= 1'b0;
            interp_enable <= 1'b0;
        end else begin
            serial_data_oe <= ~pins.cs_n & ~standalone_s;
            interp_enable <= standalone_s & standalone_resolution_pin;
        end
    end

    // ---------------- checks ----------------
    chk_sdo_bit_order: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
        (bit_cnt >= 5'h01 && bit_cnt <= LAST_BIT) |-> serial_data_out == status_frz[LAST_BIT - bit_cnt])
        else $error("returned bit does not match status word");
    chk_word_toggle: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
        (bit_cnt != LAST_BIT && bit_cnt != OVER_BIT) |=> $stable(rx_toggle))
        else $error("word toggle moved away from bit 20");
    chk_reset_step_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!standalone_s && !$past(standalone_s) && $past(cfg) == CFG_RESET && !$past(apply)) |-> !cfg.direct_mode)
        else $error("step interface off without a command");
    chk_single_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!cfg.both_edge_step_select && step_fall && !standalone_s) |=> usteps == $past(usteps))
        else $error("falling step edge counted in single-edge mode");
    chk_step_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (step_event && pins.dir && !cfg.direct_mode) |=> usteps == $past(usteps) - $past(step_size))
        else $error("high direction did not count down");
    chk_step_forward: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (step_event && !pins.dir && !cfg.direct_mode) |=> usteps == $past(usteps) + $past(step_size))
        else $error("low direction did not count up");
    chk_full_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg.microstep_resolution == RES_FULL |-> step_size == 10'h100)
        else $error("full step size wrong");
    chk_table_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!cfg.direct_mode && eff_scale == SA_CS_HI) |=> coil_a_target == $past(sine_a))
        else $error("coil a target not the table value");
    chk_direct_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (apply && rx_hold[19:18] == CMD_COIL) |=> coil_direct_a == $past($signed(rx_hold[17:9])))
        else $error("direct coil value not taken");
    chk_setup_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (apply && rx_hold[19:18] == CMD_CURR) |=> cfg.current_scale == $past(rx_hold[4:0]))
        else $error("current scale write lost");
    chk_sa_resolution: assert property (@(posedge ref_clk) disable iff (!rst_n)
        standalone_s |=> cfg.microstep_resolution == ($past(pins.sdi) ? RES_16 : RES_256))
        else $error("stand-alone resolution wrong");
    chk_sa_current: assert property (@(posedge ref_clk) disable iff (!rst_n)
        standalone_s |=> cfg.current_scale == ($past(pins.cs_n) ? SA_CS_HI : SA_CS_LO))
        else $error("stand-alone current scale wrong");
    chk_sa_hyst: assert property (@(posedge ref_clk) disable iff (!rst_n)
        standalone_s |=> cfg.hysteresis_start_value == ($past(pins.sck) ? SA_HYSTERESIS_START_VALUE_HI : SA_HYSTERESIS_START_VALUE_LO))
        else $error("stand-alone hysteresis wrong");
    chk_sa_no_sdo: assert property (@(posedge ref_clk) disable iff (!rst_n)
        standalone_s |=> !serial_data_oe)
        else $error("serial output driven in stand-alone mode");
    chk_apply_on_cs: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!standalone_s && !$past(standalone_s) && cfg != $past(cfg)) |-> $past(cs_rise))
        else $error("setup changed without a select rise");
    chk_load_lower: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cfg.load_adapt && cfg.current_scale > {load_level, 1'b1}) |-> eff_scale < cfg.current_scale)
        else $error("load level did not lower the scale");
    cov_step: cover property (@(posedge ref_clk) disable iff (!rst_n) step_event ##[1:40] step_event);
    cov_apply: cover property (@(posedge ref_clk) disable iff (!rst_n) apply);
    cov_standalone: cover property (@(posedge ref_clk) disable iff (!rst_n) standalone_s ##1 interp_enable);
endmodule : ssc_top
`default_nettype wire

// >>> design/ssc_pkg.sv
// ssc_pkg: constants, field layouts and types of the step/dir and serial control block
// assumes a 100 MHz ref_clk; the serial port runs on its own bus clock
package ssc_pkg;
    // serial word
    localparam int WORD_BITS = 20;
    localparam logic [4:0] LAST_BIT = 5'h13;
    localparam logic [4:0] OVER_BIT = 5'h14;
    localparam logic [4:0] CNT_SAT = 5'h15;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OFF_TIME_NS = 1000;
    localparam int OFF_CYC = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HYST_UNIT_CYC = 4;
    // command selector in word bits [19:18]
    localparam logic [1:0] CMD_COIL = 2'h0;
    localparam logic [1:0] CMD_STEP = 2'h1;
    localparam logic [1:0] CMD_CHOP = 2'h2;
    localparam logic [1:0] CMD_CURR = 2'h3;
    // field positions in the command word
    localparam int F_COIL_A = 9;
    localparam int F_COIL_B = 0;
    localparam int F_DIRECT = 9;
    localparam int F_BOTH_EDGE_STEP_SELECT = 8;
    localparam int F_RES = 0;
    localparam int F_CHOP = 14;
    localparam int F_HYSTERESIS_END_VALUE = 4;
    localparam int F_HYSTERESIS_START_VALUE = 0;
    localparam int F_CSCALE = 0;
    localparam int F_LOAD = 5;
    // resolution codes, 256 microsteps down to full step
    localparam logic [3:0] RES_256 = 4'h0;
    localparam logic [3:0] RES_16 = 4'h4;
    localparam logic [3:0] RES_FULL = 4'h8;
    localparam logic [9:0] COS_OFFSET = 10'h100;
    // stand-alone settings
    localparam logic [3:0] SA_HYSTERESIS_END_VALUE = 4'h4;
    localparam logic [2:0] SA_HYSTERESIS_START_VALUE_LO = 3'h2;
    localparam logic [2:0] SA_HYSTERESIS_START_VALUE_HI = 3'h6;
    localparam logic [4:0] SA_CS_LO = 5'h0f;
    localparam logic [4:0] SA_CS_HI = 5'h1f;
    typedef enum logic {CHOP_CONST_OFF = 1'b0, CHOP_SPREAD = 1'b1} ssc_chop_t;
    typedef enum logic [2:0] {CH_ON = 3'b001, CH_FAST = 3'b010, CH_SLOW = 3'b100} ssc_chst_t;
    typedef struct packed {
        logic direct_mode;
        logic both_edge_step_select;
        logic [3:0] microstep_resolution;
        ssc_chop_t chop_mode;
        logic [3:0] hysteresis_end_value;
        logic [2:0] hysteresis_start_value;
        logic [4:0] current_scale;
        logic load_adapt;
    } ssc_cfg_t;
    localparam ssc_cfg_t CFG_RESET = '{direct_mode: 1'b0, both_edge_step_select: 1'b0,
        microstep_resolution: RES_256, chop_mode: CHOP_SPREAD, hysteresis_end_value: SA_HYSTERESIS_END_VALUE,
        hysteresis_start_value: SA_HYSTERESIS_START_VALUE_LO, current_scale: SA_CS_HI, load_adapt: 1'b0};
    // pins and cross-domain levels that pass the synchroniser
    typedef struct packed {
        logic step;
        logic dir;
        logic cs_n;
        logic sdi;
        logic sck;
        logic standalone;
        logic over_a;
        logic over_b;
        logic toggle;
    } ssc_pins_t;
    // quarter sine, 17 points, peak 248
    localparam logic [7:0] SINE_TAB [0:16] = '{8'h00, 8'h18, 8'h30, 8'h48, 8'h5f, 8'h75, 8'h8a,
        8'h9d, 8'haf, 8'hbf, 8'hce, 8'hda, 8'he5, 8'hed, 8'hf3, 8'hf7, 8'hf8};
endpackage : ssc_pkg

// >>> design/ssc_sine_lut.sv
// ssc_sine_lut: signed sine sample of a 1024-step phase by interpolated quarter table
// assumes the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module ssc_sine_lut
    import ssc_pkg::*;
(
    // phase, 1024 per electrical period
    input wire logic [9:0] phase,
    // signed coil sample
    output logic signed [8:0] sample
);
    logic [8:0] quarter;
    logic [7:0] base;
    logic [7:0] span;
    logic [11:0] interp;
    logic [8:0] mag;

    // mirror into the first quarter, interpolate 16 steps between table points
    always_comb begin
        quarter = phase[8] ? (9'h100 - {1'b0, phase[7:0]}) : {1'b0, phase[7:0]};
        base = SINE_TAB[quarter[8:4]];
        span = (quarter[8:4] == 5'h10) ? 8'h00 : SINE_TAB[quarter[8:4] + 5'h01] - base;
        interp = span * quarter[3:0];
        mag = {1'b0, base} + {5'h00, interp[11:8]} * 9'h010 + {5'h00, interp[7:4]};
        sample = phase[9] ? -$signed(mag) : $signed(mag);
    end
endmodule : ssc_sine_lut
`default_nettype wire

// >>> design/ssc_chopper.sv
// ssc_chopper: cycle-by-cycle chopper phase sequencer for one coil
// assumes a synchronised comparator flag that goes high at the target current
`timescale 1ns/100ps
`default_nettype none
module ssc_chopper
    import ssc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // setup
    input wire logic spread,
    input wire logic [4:0] hyst_len,
    // comparator
    input wire logic over,
    // phase out
    output ssc_chst_t phase_st
);
    logic [7:0] timer;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_st <= CH_ON;
            timer <= 8'h00;
        end else begin
            case (phase_st)
                CH_ON: begin
                    if (over) begin
                        phase_st <= spread ? CH_FAST : CH_SLOW;
                        timer <= spread ? 8'(hyst_len * HYST_UNIT_CYC + 1) : 8'(OFF_CYC);
                    end
                end
                CH_FAST: begin
                    if (timer <= 8'h01) begin
                        phase_st <= CH_SLOW;
                        timer <= 8'(OFF_CYC);
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                CH_SLOW: begin
                    if (timer <= 8'h01) phase_st <= CH_ON;
                    else timer <= timer - 8'h01;
                end
                default: phase_st <= CH_ON;
            endcase
        end
    end

    chk_const_off_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (phase_st == CH_ON && over && !spread) |=> (phase_st == CH_SLOW) [*8])
        else $error("constant off-time phase left early");
    cov_fast_decay: cover property (@(posedge ref_clk) disable iff (!rst_n)
        phase_st == CH_FAST ##1 phase_st == CH_SLOW);
endmodule : ssc_chopper
`default_nettype wire

// >>> bench/ssc_spi_master.sv
// ssc_spi_master: serial bus master model
// assumes the bench calls xfer; clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module ssc_spi_master (
    // serial pins
    output logic serial_clk,
    output logic chip_sel_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        serial_clk = 1'b0;
        chip_sel_n = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic xfer(input logic [19:0] cmd, input int nbits, output logic [19:0] stat);
        #3 chip_sel_n = 1'b0; // keeps link edges off the system clock edges
        #80;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_data_in = cmd[i % 20];
            #80 serial_clk = 1'b1;
            stat = {stat[18:0], serial_data_out}; // one bit back per bit
            #80 serial_clk = 1'b0;
        end
        #80 chip_sel_n = 1'b1;
        serial_data_in = ~serial_data_in; // released line shows no stale bit
        #100;
    endtask : xfer
endmodule : ssc_spi_master
`default_nettype wire

// >>> bench/ssc_top_tb_top.sv
// ssc_top_tb_top: bench for stepping, serial commands and straps
// assumes ssc_spi_master owns the serial pins
`timescale 1ns/100ps
`default_nettype none
module ssc_top_tb_top import ssc_pkg::*; ;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b1;
    logic ov = 1'b0;
    logic step_in = 1'b0;
    logic dir_in = 1'b0;
    logic sa_pin = 1'b0;
    wire logic sck, cs_n, sdi, sdo, sdo_oe;
    logic signed [8:0] ca, cb;
    ssc_chst_t pa, pb;
    logic interp;
    logic [19:0] st;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    ssc_spi_master i_m (.serial_clk(sck), .chip_sel_n(cs_n), .serial_data_in(sdi),
        .serial_data_out(sdo));
    ssc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(sck), .chip_sel_n(cs_n),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
        .step_in(step_in), .dir_in(dir_in), .standalone_select_pin(sa_pin),
        .coil_a_over(ov), .coil_b_over(ov), .load_level(4'h7),
        .coil_a_target(ca), .coil_b_target(cb), .chop_a_phase(pa),
        .chop_b_phase(pb), .interp_enable(interp));
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one step line toggle, direction set well ahead
    task automatic stp(input logic d);
        @(posedge ref_clk) dir_in <= d;
        repeat (4) @(posedge ref_clk);
        step_in <= ~step_in;
        repeat (8) @(posedge ref_clk);
    endtask : stp
    task automatic pulse(input logic d);
        stp(d);
        stp(d);
    endtask : pulse
    task automatic wr(input logic [19:0] w);
        i_m.xfer(w, 20, st);
    endtask : wr
    task automatic t_count;
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b1);
        wr(20'h84042);
        chk("counter", st[18:9], 20'h3ff);
        chk("last_dir", st[2], 20'h1);
        pulse(1'b0);
    endtask : t_count
    task automatic t_full;
        wr(20'h40108);
        stp(1'b0);
        stp(1'b0);
        wr(20'h84042);
        chk("counter", st[18:9], 20'h200);
        chk("coil_a", {11'h0, ca}, 20'h0);
        chk("coil_b", {11'h0, cb}, 20'h108);
        wr(20'hc0007);
        chk("coil_b", {11'h0, cb}, 20'h1c2);
        wr(20'hc003f);
        chk("coil_b", {11'h0, cb}, 20'h184);
        wr(20'hc001f);
    endtask : t_full
    task automatic t_direct;
        wr(20'h40200);
        wr(20'h0abfd);
        chk("coil_a", {11'h0, ca}, 20'h055);
        chk("coil_b", {11'h0, cb}, 20'h1fd);
        i_m.xfer(20'h0, 21, st);
        chk("coil_a", {11'h0, ca}, 20'h055);
        pulse(1'b0);
        wr(20'h84042);
        chk("counter", st[18:9], 20'h200);
        chk("direct", st[7], 20'h1);
    endtask : t_direct
    // one over pulse per chopper mode: fast decay (2+4)*4+1 cycles when spread, then 100 slow
    task automatic t_chop(input logic spread);
        wr({4'h8, 1'b0, spread, 14'h0042});
        @(posedge ref_clk) ov <= 1'b1;
        @(posedge ref_clk) ov <= 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("chop_a", pa, spread ? CH_FAST : CH_SLOW);
        chk("chop_b", pb, spread ? CH_FAST : CH_SLOW);
        repeat (30) @(negedge ref_clk);
        chk("chop_a", pa, CH_SLOW);
        repeat (100) @(negedge ref_clk);
        chk("chop_a", pa, CH_ON);
        chk("chop_b", pb, CH_ON);
    endtask : t_chop
    task automatic t_strap;
        @(posedge ref_clk) i_m.chip_sel_n <= 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("sdo_oe", sdo_oe, 20'h1);
        @(posedge ref_clk) sa_pin <= 1'b1;
        i_m.serial_data_in <= 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("interp", interp, 20'h1);
        chk("sdo_oe", sdo_oe, 20'h0);
        chk("coil_b", {11'h0, cb}, 20'h184);
        @(posedge ref_clk) i_m.serial_data_in <= 1'b0;
        i_m.chip_sel_n <= 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("interp", interp, 20'h0);
        chk("coil_b", {11'h0, cb}, 20'h108);
    endtask : t_strap
    task automatic complete_run;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        t_count();
        t_full();
        t_direct();
        t_chop(1'b0);
        t_chop(1'b1);
        t_strap();
        complete_run();
    end
endmodule : ssc_top_tb_top
`default_nettype wire
